/* File: src/spk_pkg.sv */
`default_nettype none
package spk_pkg;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [15:0] ADDR_MAIN = 16'h0052;
    localparam logic [15:0] ADDR_PROT = 16'h0056;
    localparam logic [15:0] ADDR_OCMON = 16'h005e;
    localparam logic [15:0] ADDR_MOD = 16'h0062;
    localparam logic [15:0] ADDR_GAIN = 16'h0064;
    localparam logic [15:0] ADDR_OVR = 16'h006a;
    // ----------------------------------------
    // reset values and writable masks
    // ----------------------------------------
    localparam logic [15:0] RST_MAIN = 16'h0000;
    localparam logic [15:0] RST_PROT = 16'h0014;
    localparam logic [15:0] RST_OCMON = 16'h0000;
    localparam logic [15:0] RST_MOD = 16'h0000;
    localparam logic [15:0] RST_GAIN = 16'h2000;
    localparam logic [15:0] RST_OVR = 16'h0000;
    localparam logic [15:0] MASK_MAIN = 16'h0305;
    localparam logic [15:0] MASK_PROT = 16'h064d;
    localparam logic [15:0] MASK_OCMON = 16'h0f00;
    localparam logic [15:0] MASK_MOD = 16'h00f0;
    localparam logic [15:0] MASK_GAIN = 16'h0f00;
    localparam logic [15:0] MASK_OVR = 16'h0aa9;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int MAIN_AMP_ON = 0;
    localparam int MAIN_DRV_TYPE = 2;
    localparam int MAIN_OC_CUT = 8;
    localparam int MAIN_THERM = 9;
    localparam int PROT_INTG = 0;
    localparam int PROT_SLEW = 2;
    localparam int PROT_RCV = 6;
    localparam int PROT_AB_OC = 9;
    localparam int PROT_D_OC = 10;
    localparam int OC_WND = 8;
    localparam int OC_THD = 10;
    localparam int OC_D_FLAG = 14;
    localparam int OC_AB_FLAG = 15;
    localparam int MOD_CODE = 4;
    localparam int GAIN_CODE = 8;
    localparam int OVR_PATH = 0;
    localparam int OVR_CD_HOLD = 3;
    localparam int OVR_DRV_TYPE = 5;
    localparam int OVR_DEPOP = 7;
    localparam int OVR_AMP_ON = 9;
    localparam int OVR_STAGE = 11;
    // ----------------------------------------
    // decision window timing
    // ----------------------------------------
    localparam int CLK_NS = 25;
    localparam int WIN16_NS = 16000;
    localparam int WIN32_NS = 32000;
    localparam int WIN64_NS = 64000;
    localparam int WIN128_NS = 128000;
    localparam logic [12:0] WIN16_CYC = 13'(WIN16_NS / CLK_NS);
    localparam logic [12:0] WIN32_CYC = 13'(WIN32_NS / CLK_NS);
    localparam logic [12:0] WIN64_CYC = 13'(WIN64_NS / CLK_NS);
    localparam logic [12:0] WIN128_CYC = 13'(WIN128_NS / CLK_NS);
    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } spk_req_t;
    typedef struct packed {
        logic amp_on;
        logic driver_ab;
        logic output_stage_on;
        logic receiver_bypass;
        logic integrator_hold;
        logic classd_hold;
        logic depop_on;
        logic [1:0] edge_rate;
        logic [2:0] mod_freq;
        logic [3:0] gain;
    } spk_ctrl_t;
endpackage : spk_pkg
`default_nettype wire

/* File: src/spk_amp_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module spk_amp_ctrl #(
    parameter logic [12:0] WIN128_CYCLES = spk_pkg::WIN128_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire spk_pkg::spk_req_t req,
    input wire logic over_temp,
    input wire logic oc_raw_classd,
    input wire logic oc_raw_classab,
    output var spk_pkg::spk_ctrl_t amp_ctrl,
    output logic [15:0] reg_rdata,
    output logic classd_overcurrent_flag,
    output logic classab_overcurrent_flag
);
    import spk_pkg::*;

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [15:0] speaker_main_control;
    logic [15:0] speaker_protection_tuning;
    logic [15:0] speaker_overcurrent_monitor;
    logic [15:0] speaker_modulation_clock;
    logic [15:0] speaker_gain;
    logic [15:0] speaker_software_override;

    // bits outside the mask keep their reset value
    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [15:0] val, input logic [15:0] mask);
        return (val & mask) | (old & ~mask);
    endfunction : merge

    always_ff @(posedge clock) begin
        if (rst) begin
            speaker_main_control <= RST_MAIN;
            speaker_protection_tuning <= RST_PROT;
            speaker_overcurrent_monitor <= RST_OCMON;
            speaker_modulation_clock <= RST_MOD;
            speaker_gain <= RST_GAIN;
            speaker_software_override <= RST_OVR;
        end else if (req.wr) begin
            case (req.addr)
                ADDR_MAIN: speaker_main_control <= merge(speaker_main_control, req.wdata, MASK_MAIN);
                ADDR_PROT: speaker_protection_tuning <= merge(speaker_protection_tuning, req.wdata, MASK_PROT);
                ADDR_OCMON: speaker_overcurrent_monitor <= merge(speaker_overcurrent_monitor, req.wdata, MASK_OCMON);
                ADDR_MOD: speaker_modulation_clock <= merge(speaker_modulation_clock, req.wdata, MASK_MOD);
                ADDR_GAIN: speaker_gain <= merge(speaker_gain, req.wdata, MASK_GAIN);
                ADDR_OVR: speaker_software_override <= merge(speaker_software_override, req.wdata, MASK_OVR);
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [1:0] ot_sync;
    logic [1:0] cd_sync;
    logic [1:0] ab_sync;

    always_ff @(posedge clock) begin
        if (rst) begin
            ot_sync <= 2'h0;
            cd_sync <= 2'h0;
            ab_sync <= 2'h0;
        end else begin
            ot_sync <= {ot_sync[0], over_temp};
            cd_sync <= {cd_sync[0], oc_raw_classd};
            ab_sync <= {ab_sync[0], oc_raw_classab};
        end
    end

    // ----------------------------------------
    // path selection and protection
    // ----------------------------------------
    logic sw_path;
    logic eff_amp_on;
    logic eff_ab;
    logic eff_stage;
    logic thermal_cut;
    logic oc_cut;
    spk_ctrl_t next_ctrl;

    assign sw_path = speaker_software_override[OVR_PATH];
    assign eff_amp_on = sw_path ? speaker_software_override[OVR_AMP_ON] : speaker_main_control[MAIN_AMP_ON];
    assign eff_ab = sw_path ? speaker_software_override[OVR_DRV_TYPE] : speaker_main_control[MAIN_DRV_TYPE];
    assign eff_stage = sw_path ? speaker_software_override[OVR_STAGE] : eff_amp_on;
    assign thermal_cut = ot_sync[1] & speaker_main_control[MAIN_THERM];
    // ab flag only rises while its protection is armed
    assign oc_cut = (classd_overcurrent_flag & speaker_main_control[MAIN_OC_CUT] & !eff_ab)
        | (classab_overcurrent_flag & eff_ab);

    always_comb begin
        next_ctrl = '0;
        next_ctrl.amp_on = eff_amp_on & !thermal_cut;
        next_ctrl.driver_ab = eff_ab;
        next_ctrl.output_stage_on = eff_stage & !thermal_cut & !oc_cut;
        next_ctrl.receiver_bypass = speaker_protection_tuning[PROT_RCV];
        next_ctrl.integrator_hold = speaker_protection_tuning[PROT_INTG];
        next_ctrl.classd_hold = sw_path & speaker_software_override[OVR_CD_HOLD];
        next_ctrl.depop_on = sw_path & speaker_software_override[OVR_DEPOP] & !eff_ab;
        next_ctrl.edge_rate = speaker_protection_tuning[PROT_SLEW +: 2];
        // top code bit has no effect
        next_ctrl.mod_freq = speaker_modulation_clock[MOD_CODE +: 3];
        next_ctrl.gain = speaker_gain[GAIN_CODE +: 4];
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            amp_ctrl <= '0;
        end else begin
            amp_ctrl <= next_ctrl;
        end
    end

    // ----------------------------------------
    // overcurrent monitor
    // ----------------------------------------
    logic [1:0] wnd_code;
    logic [1:0] thd_code;
    logic [12:0] win_len;
    logic [12:0] thr_hits;
    logic [12:0] win_cnt;
    logic win_end;
    logic [12:0] d_hits;
    logic [12:0] ab_hits;
    logic d_hit;
    logic ab_hit;
    logic [12:0] d_sum;
    logic [12:0] ab_sum;

    assign wnd_code = speaker_overcurrent_monitor[OC_WND +: 2];
    assign thd_code = speaker_overcurrent_monitor[OC_THD +: 2];

    always_comb begin
        case (wnd_code)
            2'h0: win_len = WIN16_CYC;
            2'h1: win_len = WIN32_CYC;
            2'h2: win_len = WIN64_CYC;
            default: win_len = WIN128_CYCLES;
        endcase
    end

    // eighths of the window: code 0 is 4/8 down to 1/8
    assign thr_hits = 13'((win_len >> 3) * (13'h4 - {11'h0, thd_code}));
    // a shorter window chosen after the count has passed its length closes at once
    assign win_end = win_cnt >= win_len - 13'h1;
    assign d_hit = cd_sync[1] & speaker_protection_tuning[PROT_D_OC] & !eff_ab;
    assign ab_hit = ab_sync[1] & speaker_protection_tuning[PROT_AB_OC] & eff_ab;
    assign d_sum = d_hits + {12'h0, d_hit};
    assign ab_sum = ab_hits + {12'h0, ab_hit};

    always_ff @(posedge clock) begin
        if (rst || win_end) begin
            win_cnt <= 13'h0;
        end else begin
            win_cnt <= win_cnt + 13'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            d_hits <= 13'h0;
            ab_hits <= 13'h0;
            classd_overcurrent_flag <= 1'b0;
            classab_overcurrent_flag <= 1'b0;
        end else begin
            d_hits <= win_end ? 13'h0 : d_sum;
            ab_hits <= win_end ? 13'h0 : ab_sum;
            if (d_sum >= thr_hits) begin
                classd_overcurrent_flag <= 1'b1;
            end else if (win_end) begin
                classd_overcurrent_flag <= 1'b0;
            end
            if (ab_sum >= thr_hits) begin
                classab_overcurrent_flag <= 1'b1;
            end else if (win_end) begin
                classab_overcurrent_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // readback
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 16'h0;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_MAIN: reg_rdata <= speaker_main_control;
                ADDR_PROT: reg_rdata <= speaker_protection_tuning;
                ADDR_OCMON: begin
                    reg_rdata <= speaker_overcurrent_monitor;
                    reg_rdata[OC_AB_FLAG] <= classab_overcurrent_flag;
                    reg_rdata[OC_D_FLAG] <= classd_overcurrent_flag;
                end
                ADDR_MOD: reg_rdata <= speaker_modulation_clock;
                ADDR_GAIN: reg_rdata <= speaker_gain;
                ADDR_OVR: reg_rdata <= speaker_software_override;
                default: reg_rdata <= 16'h0;
            endcase
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    property p_amp_on_write;
        req.wr && req.addr == ADDR_MAIN && !sw_path && !req.wdata[0]
        |=> ##1 !amp_ctrl.amp_on;
    endproperty
    a_amp_on_write: assert property (p_amp_on_write) else $error("amp on ignores write");

    property p_driver_type;
        !sw_path |=> amp_ctrl.driver_ab == $past(speaker_main_control[MAIN_DRV_TYPE]);
    endproperty
    a_driver_type: assert property (p_driver_type) else $error("driver type wrong");

    property p_thermal;
        ot_sync[1] && speaker_main_control[MAIN_THERM] |=> !amp_ctrl.amp_on;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal cut missed");

    property p_oc_cut;
        classd_overcurrent_flag && speaker_main_control[MAIN_OC_CUT] && !eff_ab
        |=> !amp_ctrl.output_stage_on;
    endproperty
    a_oc_cut: assert property (p_oc_cut) else $error("class d cut missed");

    property p_d_disarmed;
        !speaker_protection_tuning[PROT_D_OC] [*2] |-> $stable(d_hits) || d_hits == 13'h0;
    endproperty
    a_d_disarmed: assert property (p_d_disarmed) else $error("hits counted unarmed");

    property p_flag_read;
        req.rd && req.addr == ADDR_OCMON
        |=> reg_rdata[15:14] == $past({classab_overcurrent_flag, classd_overcurrent_flag});
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag readback wrong");

    property p_window_bound;
        win_cnt < win_len || $changed(wnd_code);
    endproperty
    a_window_bound: assert property (p_window_bound) else $error("window overrun");

    property p_flag_fall;
        $fell(classd_overcurrent_flag) |-> $past(win_end);
    endproperty
    a_flag_fall: assert property (p_flag_fall) else $error("flag fell mid window");

    property p_flag_rise;
        !classd_overcurrent_flag && d_sum >= thr_hits |=> classd_overcurrent_flag;
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag missed threshold");

    property p_gain;
        req.wr && req.addr == ADDR_GAIN |=> ##1 amp_ctrl.gain == $past(req.wdata[11:8], 2);
    endproperty
    a_gain: assert property (p_gain) else $error("gain not applied");

    property p_reset_path;
        $past(rst) |-> !sw_path && speaker_gain == RST_GAIN;
    endproperty
    a_reset_path: assert property (p_reset_path) else $error("reset values wrong");
endmodule : spk_amp_ctrl
`default_nettype wire

/* File: dv/spk_amp_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module spk_amp_ctrl_tb;
    import spk_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    // short longest window keeps the monitor runs brief
    localparam logic [12:0] WIN_SMALL = 13'h0040;
    localparam logic [15:0] ADDRS [6] = '{ADDR_MAIN, ADDR_PROT, ADDR_OCMON, ADDR_MOD, ADDR_GAIN, ADDR_OVR};
    localparam logic [15:0] RSTS [6] = '{RST_MAIN, RST_PROT, RST_OCMON, RST_MOD, RST_GAIN, RST_OVR};
    localparam logic [15:0] MASKS [6] = '{MASK_MAIN, MASK_PROT, MASK_OCMON, MASK_MOD, MASK_GAIN, MASK_OVR};
    logic clock = 1'b0;
    logic rst = 1'b1;
    spk_req_t req = '0;
    logic over_temp = 1'b0;
    logic oc_raw_classd = 1'b0;
    logic oc_raw_classab = 1'b0;
    spk_ctrl_t amp_ctrl;
    logic [15:0] reg_rdata;
    logic classd_overcurrent_flag;
    logic classab_overcurrent_flag;
    int err_total = 0;
    int checked = 0;
    logic s;
    always #12.5 clock = ~clock;
    spk_amp_ctrl #(.WIN128_CYCLES(WIN_SMALL)) i_dut (
        .clock(clock),
        .rst(rst),
        .req(req),
        .over_temp(over_temp),
        .oc_raw_classd(oc_raw_classd),
        .oc_raw_classab(oc_raw_classab),
        .amp_ctrl(amp_ctrl),
        .reg_rdata(reg_rdata),
        .classd_overcurrent_flag(classd_overcurrent_flag),
        .classab_overcurrent_flag(classab_overcurrent_flag)
    );
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s exp %h got %h", name, exp, got);
        end
    endtask : chk16
    task automatic chk1(input string name, input logic exp, input logic got);
        chk16(name, {15'h0, exp}, {15'h0, got});
    endtask : chk1
    task automatic reg_wr(input logic [15:0] addr, input logic [15:0] data);
        @(posedge clock);
        req.wr <= 1'b1;
        req.addr <= addr;
        req.wdata <= data;
        @(posedge clock);
        req.wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_chk(input string name, input logic [15:0] addr, input logic [15:0] exp);
        @(posedge clock);
        req.rd <= 1'b1;
        req.addr <= addr;
        @(posedge clock);
        req.rd <= 1'b0;
        tick(1);
        chk16(name, exp, reg_rdata);
    endtask : reg_chk
    // per 0 releases the line; the line is left as driven last
    task automatic oc_drive(input bit ab, input int n, input int per, output logic seen);
        seen = 1'b0;
        for (int k = 0; k < n; k++) begin
            @(posedge clock);
            if (ab) oc_raw_classab <= (per != 0) && (k % per == 0);
            else oc_raw_classd <= (per != 0) && (k % per == 0);
            #1;
            seen = seen | (ab ? classab_overcurrent_flag : classd_overcurrent_flag);
        end
    endtask : oc_drive
    task automatic end_sim;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        tick(60000);
        err_total++;
        $display("mismatch watchdog exp done got hang");
        end_sim;
    end
    initial begin
        tick(20);
        rst <= 1'b0;
        tick(1);
        for (int i = 0; i < 6; i++) reg_chk("reset", ADDRS[i], RSTS[i]);
        reg_wr(16'h0054, 16'hffff);
        reg_chk("unmapped", 16'h0054, 16'h0000);
        foreach (ADDRS[i]) begin
            reg_wr(ADDRS[i], 16'hffff);
            reg_chk("ones", ADDRS[i], MASKS[i] | (RSTS[i] & ~MASKS[i]));
            reg_wr(ADDRS[i], 16'h0000);
            reg_chk("zeros", ADDRS[i], RSTS[i] & ~MASKS[i]);
        end
        for (int c = 0; c < 16; c++) begin
            reg_wr(ADDR_MOD, 16'(c) << 4);
            reg_wr(ADDR_GAIN, 16'(c) << 8);
            reg_wr(ADDR_PROT, 16'(c[1:0]) << 2);
            tick(3);
            chk16("mod_freq", 16'(c[2:0]), 16'(amp_ctrl.mod_freq));
            chk16("gain", 16'(c[3:0]), 16'(amp_ctrl.gain));
            chk16("edge_rate", 16'(c[1:0]), 16'(amp_ctrl.edge_rate));
        end
        reg_wr(ADDR_PROT, 16'h0041);
        reg_wr(ADDR_MAIN, 16'h0005);
        tick(3);
        chk1("amp_on", 1'b1, amp_ctrl.amp_on);
        chk1("driver_ab", 1'b1, amp_ctrl.driver_ab);
        chk1("bypass", 1'b1, amp_ctrl.receiver_bypass);
        chk1("intg", 1'b1, amp_ctrl.integrator_hold);
        chk1("cd_hold", 1'b0, amp_ctrl.classd_hold);
        reg_wr(ADDR_MAIN, 16'h0201);
        reg_wr(ADDR_PROT, 16'h0000);
        @(posedge clock);
        over_temp <= 1'b1;
        tick(6);
        chk1("hot amp_on", 1'b0, amp_ctrl.amp_on);
        chk1("driver_d", 1'b0, amp_ctrl.driver_ab);
        chk1("bypass off", 1'b0, amp_ctrl.receiver_bypass);
        reg_wr(ADDR_MAIN, 16'h0001);
        tick(3);
        chk1("hot no cut", 1'b1, amp_ctrl.amp_on);
        @(posedge clock);
        over_temp <= 1'b0;
        reg_wr(ADDR_OVR, 16'h0aa9);
        tick(3);
        chk1("sw amp_on", 1'b1, amp_ctrl.amp_on);
        chk1("sw driver", 1'b1, amp_ctrl.driver_ab);
        chk1("sw stage", 1'b1, amp_ctrl.output_stage_on);
        chk1("sw depop ab", 1'b0, amp_ctrl.depop_on);
        chk1("sw cd_hold", 1'b1, amp_ctrl.classd_hold);
        // depop only acts in class d
        reg_wr(ADDR_OVR, 16'h0a89);
        tick(3);
        chk1("sw driver d", 1'b0, amp_ctrl.driver_ab);
        chk1("sw depop", 1'b1, amp_ctrl.depop_on);
        reg_wr(ADDR_OVR, 16'h0001);
        tick(3);
        chk1("sw path off", 1'b0, amp_ctrl.amp_on);
        chk1("sw stage off", 1'b0, amp_ctrl.output_stage_on);
        chk1("sw depop off", 1'b0, amp_ctrl.depop_on);
        reg_wr(ADDR_OVR, 16'h0000);
        // window 64 cycles, 8 hits; wait out any longer window in flight
        reg_wr(ADDR_OCMON, 16'h0f00);
        reg_wr(ADDR_MAIN, 16'h0101);
        tick(700);
        oc_drive(1'b0, 200, 1, s);
        chk1("d unarmed", 1'b0, s);
        reg_wr(ADDR_PROT, 16'h0400);
        oc_drive(1'b0, 200, 1, s);
        chk1("d flag", 1'b1, s);
        reg_chk("d status", ADDR_OCMON, 16'h4f00);
        chk1("d cut stage", 1'b0, amp_ctrl.output_stage_on);
        chk1("d cut amp", 1'b1, amp_ctrl.amp_on);
        oc_drive(1'b0, 200, 0, s);
        chk1("d clear", 1'b0, classd_overcurrent_flag);
        oc_drive(1'b0, 300, 8, s);
        chk1("one eighth", 1'b1, s);
        reg_wr(ADDR_OCMON, 16'h0b00);
        oc_drive(1'b0, 200, 0, s);
        oc_drive(1'b0, 300, 8, s);
        chk1("two eighths", 1'b0, s);
        reg_wr(ADDR_MAIN, 16'h0005);
        reg_wr(ADDR_PROT, 16'h0200);
        oc_drive(1'b1, 200, 1, s);
        chk1("ab flag", 1'b1, s);
        reg_chk("ab status", ADDR_OCMON, 16'h8b00);
        chk1("ab d flag", 1'b0, classd_overcurrent_flag);
        chk1("ab cut stage", 1'b0, amp_ctrl.output_stage_on);
        oc_drive(1'b1, 200, 0, s);
        chk1("ab clear", 1'b0, classab_overcurrent_flag);
        // window codes 0..2, threshold code equal to window code
        reg_wr(ADDR_MAIN, 16'h0001);
        reg_wr(ADDR_PROT, 16'h0400);
        for (int w = 0; w < 3; w++) begin
            reg_wr(ADDR_OCMON, 16'(w) * 16'h0500);
            oc_drive(1'b0, 2 * (int'(WIN16_CYC) << w) + 8, 0, s);
            chk1("win clear", 1'b0, classd_overcurrent_flag);
            // quarter duty meets only the 2/8 threshold
            oc_drive(1'b0, 2 * (int'(WIN16_CYC) << w) + 8, 4, s);
            chk1("quarter duty", w == 2, s);
            oc_drive(1'b0, 2 * (int'(WIN16_CYC) << w) + 8, 2, s);
            chk1("half duty", 1'b1, s);
            chk1("no cut stage", 1'b1, amp_ctrl.output_stage_on);
        end
        end_sim;
    end
endmodule : spk_amp_ctrl_tb
`default_nettype wire
